// ===== rtl/bbw_addr_gen.sv
// next-beat address of a burst from its type, size and length
// purely combinational; the slave registers the result
`timescale 1ns/100ps
`default_nettype none
module bbw_addr_gen #(
  parameter int AW = bbw_pkg::ADDR_W
) (
  // current beat
  input  wire logic [AW-1:0]               addr_in,
  input  wire logic [bbw_pkg::SIZE_W-1:0]  size_in,
  input  wire logic [bbw_pkg::BURST_W-1:0] burst_in,
  input  wire logic [bbw_pkg::LEN_W-1:0]   len_in,
  // following beat
  output logic      [AW-1:0]               next_out
);
  logic [AW-1:0] bytes;
  logic [AW-1:0] aligned;
  logic [AW-1:0] stepped;
  logic [AW-1:0] wrap_mask;

  // unaligned incrementing and wrapping starts are aligned from the second beat onward
  always_comb begin
    bytes     = AW'(1) << size_in;
    aligned   = addr_in & ~(bytes - AW'(1));
    stepped   = aligned + bytes;
    wrap_mask = AW'(bytes * (AW'(len_in) + AW'(1))) - AW'(1);
    unique case (burst_in)
      bbw_pkg::BURST_FIXED: next_out = addr_in;
      bbw_pkg::BURST_WRAP:  next_out = (addr_in & ~wrap_mask)
                                       | (stepped & wrap_mask);
      // reserved code is stepped like incrementing, the safe reading
      default:              next_out = stepped;
    endcase
  end
endmodule
`default_nettype wire

// ===== rtl/bbw_if.sv
// write address, write data and write response channels between two ends
// assumes the bench drives aresetn and both ends share one rising-edge clock
`timescale 1ns/100ps
`default_nettype none
interface bbw_if #(
  parameter int AW  = bbw_pkg::ADDR_W,
  parameter int DW  = bbw_pkg::DATA_W,
  parameter int IDW = bbw_pkg::ID_W
) (
  input wire logic aresetn
);
  // write address channel
  logic [IDW-1:0]              aw_id;
  logic [AW-1:0]               aw_addr;
  logic [bbw_pkg::LEN_W-1:0]   aw_len;
  logic [bbw_pkg::SIZE_W-1:0]  aw_size;
  logic [bbw_pkg::BURST_W-1:0] aw_burst;
  logic [bbw_pkg::LOCK_W-1:0]  aw_lock;
  logic [bbw_pkg::CACHE_W-1:0] aw_cache;
  logic [bbw_pkg::PROT_W-1:0]  aw_prot;
  logic                        aw_valid;
  logic                        aw_ready;
  // write data channel
  logic [IDW-1:0]              w_id;
  logic [DW-1:0]               w_data;
  logic [DW/8-1:0]             w_strb;
  logic                        w_last;
  logic                        w_valid;
  logic                        w_ready;
  // write response channel
  logic [IDW-1:0]              b_id;
  logic [bbw_pkg::RESP_W-1:0]  b_resp;
  logic                        b_valid;
  logic                        b_ready;

  modport mst (
    input  aresetn, aw_ready, w_ready, b_id, b_resp, b_valid,
    output aw_id, aw_addr, aw_len, aw_size, aw_burst, aw_lock, aw_cache,
           aw_prot, aw_valid, w_id, w_data, w_strb, w_last, w_valid, b_ready
  );
  modport slv (
    input  aresetn, aw_id, aw_addr, aw_len, aw_size, aw_burst, aw_lock,
           aw_cache, aw_prot, aw_valid, w_id, w_data, w_strb, w_last,
           w_valid, b_ready,
    output aw_ready, w_ready, b_id, b_resp, b_valid
  );
endinterface
`default_nettype wire

// ===== rtl/bbw_master.sv
// master end: turns user commands and beats into write bursts on the link
// assumes the slave keeps its handshakes; clock shared with the slave
//
// Operation
// - next address may follow once previous accepted
// - address first, then the burst's data beats
// - last flag high only on final beat
// - slave answers once after all beats taken
// - same tag completes in order, others free
// - in-order needs one shared tag
// - interconnect widens tags to be unique
// - simple ends may ignore tag order
// - everything sampled on rising clock edge
// - link reset asserted when low
// - write address tag is four bits
// - only start byte address is sent
// - length field counts beats on both sides
// - size field gives each beat's size
// - slave steps address by burst type, size
// - lock field gives atomic character
// - cache field gives caching attributes
// - protection field gives access level, kind
// - address held stable until ready seen
// - slave ready shows it can take address
// - data and tag widths are parameters
// - slave accepts unaligned start addresses
// - transfer only when valid and ready high
`timescale 1ns/100ps
`default_nettype none
module bbw_master #(
  parameter int                  AW    = bbw_pkg::ADDR_W,
  parameter int                  DW    = bbw_pkg::DATA_W,
  parameter int                  IDW   = bbw_pkg::ID_W,
  parameter int                  TAG_W = 1,
  parameter logic [TAG_W-1:0]    TAG   = '0
) (
  // clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        sys_rst_in,
  // link
  bbw_if.mst                               bus,
  // burst commands
  input  wire logic                        cmd_valid_in,
  output logic                             cmd_ready_out,
  input  wire logic [IDW-TAG_W-1:0]        cmd_id_in,
  input  wire logic [AW-1:0]               cmd_addr_in,
  input  wire logic [bbw_pkg::LEN_W-1:0]   cmd_len_in,
  input  wire logic [bbw_pkg::SIZE_W-1:0]  cmd_size_in,
  input  wire logic [bbw_pkg::BURST_W-1:0] cmd_burst_in,
  input  wire logic [bbw_pkg::LOCK_W-1:0]  cmd_lock_in,
  input  wire logic [bbw_pkg::CACHE_W-1:0] cmd_cache_in,
  input  wire logic [bbw_pkg::PROT_W-1:0]  cmd_prot_in,
  // data beats
  input  wire logic                        wd_valid_in,
  output logic                             wd_ready_out,
  input  wire logic [DW-1:0]               wd_data_in,
  input  wire logic [DW/8-1:0]             wd_strb_in,
  // completions
  output logic                             rsp_valid_out,
  output logic [IDW-1:0]                   rsp_id_out,
  output logic [bbw_pkg::RESP_W-1:0]       rsp_resp_out
);
  // the data width must be whole bytes and the tag must leave user bits
  if (DW % bbw_pkg::BYTE_W != 0 || TAG_W < 1 || TAG_W >= IDW)
    $error("bbw_master: unsupported width parameters");

  logic                      rst;
  logic                      cmd_take, aw_hs, w_hs, beat_take;
  logic                      beat_last;
  logic                      aw_nxt, wv_nxt;
  logic                      dact_r, dact_nxt, qv_r, qv_nxt;
  logic [bbw_pkg::LEN_W-1:0] dlen_r, dlen_nxt, qlen_r, qlen_nxt;
  logic [bbw_pkg::LEN_W-1:0] bcnt_r, bcnt_nxt;
  logic [IDW-1:0]            did_r, did_nxt, qid_r, qid_nxt;

  // link reset is active low and joins the local reset
  assign rst = sys_rst_in || !bus.aresetn;

  // handshakes: a transfer only on an edge with valid and ready both high
  always_comb begin
    cmd_take  = cmd_valid_in && cmd_ready_out;
    aw_hs     = bus.aw_valid && bus.aw_ready;
    w_hs      = bus.w_valid && bus.w_ready;
    beat_take = wd_valid_in && wd_ready_out;
    beat_last = bcnt_r == dlen_r;
  end

  // address valid: raised on a command, dropped only by the slave's ready
  always_comb begin
    aw_nxt = bus.aw_valid;
    if (aw_hs)
      aw_nxt = 1'b0;
    if (cmd_take)
      aw_nxt = 1'b1;
  end

  // data bookkeeping: the burst whose beats are due and one queued behind
  // it; data only becomes due once its address has been accepted
  always_comb begin
    dact_nxt = dact_r;
    dlen_nxt = dlen_r;
    did_nxt  = did_r;
    qv_nxt   = qv_r;
    qlen_nxt = qlen_r;
    qid_nxt  = qid_r;
    bcnt_nxt = bcnt_r;
    if (beat_take) begin
      bcnt_nxt = bcnt_r + bbw_pkg::LEN_ONE;
      if (beat_last) begin
        dact_nxt = qv_r;
        dlen_nxt = qlen_r;
        did_nxt  = qid_r;
        qv_nxt   = 1'b0;
        bcnt_nxt = bbw_pkg::LEN_ZERO;
      end
    end
    if (aw_hs) begin
      if (!dact_nxt) begin
        dact_nxt = 1'b1;
        dlen_nxt = bus.aw_len;
        did_nxt  = bus.aw_id;
      end else begin
        qv_nxt   = 1'b1;
        qlen_nxt = bus.aw_len;
        qid_nxt  = bus.aw_id;
      end
    end
  end

  // write data valid: set by a user beat, cleared by the slave's ready
  always_comb begin
    wv_nxt = bus.w_valid;
    if (w_hs)
      wv_nxt = 1'b0;
    if (beat_take)
      wv_nxt = 1'b1;
  end

  // address valid stays low through reset and rises only after it
  always_ff @(posedge clk_in) begin
    if (rst) begin
      bus.aw_valid  <= bbw_pkg::IDLE_LOW;
      cmd_ready_out <= bbw_pkg::IDLE_LOW;
    end else begin
      bus.aw_valid  <= aw_nxt;
      // one command in flight and a free queue slot; the next address
      // need not wait for the earlier burst's data
      cmd_ready_out <= !aw_nxt && !qv_nxt;
    end
  end

  // address fields load only on a taken command, so they hold until
  // the slave's ready is seen
  always_ff @(posedge clk_in) begin
    if (rst) begin
      bus.aw_id    <= '0;
      bus.aw_addr  <= '0;
      bus.aw_len   <= bbw_pkg::LEN_ZERO;
      bus.aw_size  <= '0;
      bus.aw_burst <= bbw_pkg::BURST_INCR;
      bus.aw_lock  <= '0;
      bus.aw_cache <= '0;
      bus.aw_prot  <= '0;
    end else if (cmd_take) begin
      // tag bits above the user tag keep masters apart
      bus.aw_id    <= {TAG, cmd_id_in};
      bus.aw_addr  <= cmd_addr_in;
      bus.aw_len   <= cmd_len_in;
      bus.aw_size  <= cmd_size_in;
      bus.aw_burst <= cmd_burst_in;
      bus.aw_lock  <= cmd_lock_in;
      bus.aw_cache <= cmd_cache_in;
      bus.aw_prot  <= cmd_prot_in;
    end
  end

  // burst tracking registers
  always_ff @(posedge clk_in) begin
    if (rst) begin
      dact_r <= bbw_pkg::IDLE_LOW;
      qv_r   <= bbw_pkg::IDLE_LOW;
      dlen_r <= bbw_pkg::LEN_ZERO;
      qlen_r <= bbw_pkg::LEN_ZERO;
      did_r  <= '0;
      qid_r  <= '0;
      bcnt_r <= bbw_pkg::LEN_ZERO;
    end else begin
      dact_r <= dact_nxt;
      qv_r   <= qv_nxt;
      dlen_r <= dlen_nxt;
      qlen_r <= qlen_nxt;
      did_r  <= did_nxt;
      qid_r  <= qid_nxt;
      bcnt_r <= bcnt_nxt;
    end
  end

  // write data stage; one beat held at a time, which costs a bubble
  // between beats but keeps the ready a plain flop
  always_ff @(posedge clk_in) begin
    if (rst) begin
      bus.w_valid  <= bbw_pkg::IDLE_LOW;
      bus.w_last   <= bbw_pkg::IDLE_LOW;
      bus.w_id     <= '0;
      bus.w_data   <= '0;
      bus.w_strb   <= '0;
      wd_ready_out <= bbw_pkg::IDLE_LOW;
    end else begin
      bus.w_valid  <= wv_nxt;
      wd_ready_out <= dact_nxt && !wv_nxt;
      if (beat_take) begin
        bus.w_last <= beat_last;
        bus.w_id   <= did_r;
        bus.w_data <= wd_data_in;
        bus.w_strb <= wd_strb_in;
      end
    end
  end

  // responses are always accepted and handed up as they come; tag order
  // is kept by the slave, differing tags may arrive in any order
  always_ff @(posedge clk_in) begin
    if (rst) begin
      bus.b_ready   <= bbw_pkg::IDLE_LOW;
      rsp_valid_out <= bbw_pkg::IDLE_LOW;
      rsp_id_out    <= '0;
      rsp_resp_out  <= bbw_pkg::RESP_OKAY;
    end else begin
      bus.b_ready   <= 1'b1;
      rsp_valid_out <= bus.b_valid && bus.b_ready;
      if (bus.b_valid && bus.b_ready) begin
        rsp_id_out   <= bus.b_id;
        rsp_resp_out <= bus.b_resp;
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/bbw_pkg.sv
// shared constants of the burst write port: widths, burst and response codes
// assumes nothing; every other file names these as bbw_pkg::name
package bbw_pkg;
  // field widths of the reference configuration
  localparam int ADDR_W  = 32;
  localparam int DATA_W  = 32;
  localparam int ID_W    = 4;
  localparam int LEN_W   = 4;
  localparam int SIZE_W  = 3;
  localparam int BURST_W = 2;
  localparam int LOCK_W  = 2;
  localparam int CACHE_W = 4;
  localparam int PROT_W  = 3;
  localparam int RESP_W  = 2;
  localparam int BYTE_W  = 8;
  // burst type codes
  localparam logic [BURST_W-1:0] BURST_FIXED = 2'h0;
  localparam logic [BURST_W-1:0] BURST_INCR  = 2'h1;
  localparam logic [BURST_W-1:0] BURST_WRAP  = 2'h2;
  // response codes
  localparam logic [RESP_W-1:0]  RESP_OKAY   = 2'h0;
  localparam logic [RESP_W-1:0]  RESP_SLVERR = 2'h2;
  // reset values and count step of control state
  localparam logic               IDLE_LOW    = 1'h0;
  localparam logic [LEN_W-1:0]   LEN_ZERO    = 4'h0;
  localparam logic [LEN_W-1:0]   LEN_ONE     = 4'h1;
endpackage

// ===== rtl/bbw_slave.sv
// slave end: takes burst addresses and data, writes beats out, answers once
// assumes the master keeps its side of the handshakes; clock shared
`timescale 1ns/100ps
`default_nettype none
module bbw_slave #(
  parameter int AW  = bbw_pkg::ADDR_W,
  parameter int DW  = bbw_pkg::DATA_W,
  parameter int IDW = bbw_pkg::ID_W
) (
  // clock and reset
  input  wire logic          clk_in,
  input  wire logic          sys_rst_in,
  // link
  bbw_if.slv                 bus,
  // memory-side write beats
  output logic               wr_en_out,
  output logic [AW-1:0]      wr_addr_out,
  output logic [DW-1:0]      wr_data_out,
  output logic [DW/8-1:0]    wr_strb_out
);
  if (DW % bbw_pkg::BYTE_W != 0 || IDW < 1)
    $error("bbw_slave: data width must be whole bytes");

  logic                        rst;
  logic                        aw_hs, w_hs, load, last_beat;
  logic                        act_nxt, pend_nxt, bv_nxt;
  logic                        pend_r, act_r, err_r;
  logic [IDW-1:0]              p_id_r, id_r;
  logic [AW-1:0]               p_addr_r, addr_r, addr_nxt;
  logic [bbw_pkg::LEN_W-1:0]   p_len_r, len_r, cnt_r;
  logic [bbw_pkg::SIZE_W-1:0]  p_size_r, size_r;
  logic [bbw_pkg::BURST_W-1:0] p_burst_r, burst_r;

  // either reset source; the link reset is active low
  assign rst = sys_rst_in || !bus.aresetn;

  // handshakes count only on a shared rising edge with both high
  always_comb begin
    aw_hs     = bus.aw_valid && bus.aw_ready;
    w_hs      = bus.w_valid && bus.w_ready;
    load      = pend_r && !act_r;
    last_beat = w_hs && (cnt_r == len_r);
    act_nxt   = load ? 1'b1 : (last_beat ? 1'b0 : act_r);
    pend_nxt  = aw_hs ? 1'b1 : (load ? 1'b0 : pend_r);
    bv_nxt    = last_beat ? 1'b1
              : ((bus.b_valid && bus.b_ready) ? 1'b0 : bus.b_valid);
  end

  bbw_addr_gen #(.AW(AW)) u_gen (
    .addr_in  (addr_r),
    .size_in  (size_r),
    .burst_in (burst_r),
    .len_in   (len_r),
    .next_out (addr_nxt)
  );

  // one waiting address lets the next burst overlap the current data
  always_ff @(posedge clk_in) begin
    if (rst) begin
      pend_r       <= bbw_pkg::IDLE_LOW;
      bus.aw_ready <= bbw_pkg::IDLE_LOW;
    end else begin
      pend_r       <= pend_nxt;
      bus.aw_ready <= !pend_nxt;
    end
  end

  // address slot, written only when taken
  always_ff @(posedge clk_in) begin
    if (aw_hs) begin
      p_id_r    <= bus.aw_id;
      p_addr_r  <= bus.aw_addr;
      p_len_r   <= bus.aw_len;
      p_size_r  <= bus.aw_size;
      p_burst_r <= bus.aw_burst;
    end
  end

  // active burst: bursts are served strictly in arrival order
  always_ff @(posedge clk_in) begin
    if (rst) begin
      act_r <= bbw_pkg::IDLE_LOW;
      cnt_r <= bbw_pkg::LEN_ZERO;
      err_r <= bbw_pkg::IDLE_LOW;
    end else begin
      act_r <= act_nxt;
      if (load) begin
        cnt_r <= bbw_pkg::LEN_ZERO;
        err_r <= bbw_pkg::IDLE_LOW;
      end else if (w_hs) begin
        cnt_r <= cnt_r + bbw_pkg::LEN_ONE;
        // a last flag on the wrong beat is reported, count still rules
        if (bus.w_last != (cnt_r == len_r))
          err_r <= 1'b1;
      end
    end
  end

  // beat address walks with each accepted beat
  always_ff @(posedge clk_in) begin
    if (load) begin
      id_r    <= p_id_r;
      addr_r  <= p_addr_r;
      len_r   <= p_len_r;
      size_r  <= p_size_r;
      burst_r <= p_burst_r;
    end else if (w_hs) begin
      addr_r  <= addr_nxt;
    end
  end

  // data is refused while a response waits, so one answer per burst
  always_ff @(posedge clk_in) begin
    if (rst) begin
      bus.w_ready <= bbw_pkg::IDLE_LOW;
      bus.b_valid <= bbw_pkg::IDLE_LOW;
      bus.b_id    <= '0;
      bus.b_resp  <= bbw_pkg::RESP_OKAY;
    end else begin
      bus.w_ready <= act_nxt && !bv_nxt;
      bus.b_valid <= bv_nxt;
      if (last_beat) begin
        bus.b_id   <= id_r;
        bus.b_resp <= (err_r || !bus.w_last) ? bbw_pkg::RESP_SLVERR
                                             : bbw_pkg::RESP_OKAY;
      end
    end
  end

  // memory-side beat, one cycle after acceptance
  always_ff @(posedge clk_in) begin
    if (rst) begin
      wr_en_out   <= bbw_pkg::IDLE_LOW;
      wr_addr_out <= '0;
      wr_data_out <= '0;
      wr_strb_out <= '0;
    end else begin
      wr_en_out <= w_hs;
      if (w_hs) begin
        wr_addr_out <= addr_r;
        wr_data_out <= bus.w_data;
        wr_strb_out <= bus.w_strb;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/bbw_chk.sv
// checker of the link between the master and slave ends
// assumes one rising-edge clock; placed beside the interface, no bind
`timescale 1ns/100ps
`default_nettype none
module bbw_chk (
  // clock and link reset
  input wire logic                        clk_in,
  input wire logic                        aresetn,
  // write address channel
  input wire logic [bbw_pkg::ID_W-1:0]    aw_id,
  input wire logic [bbw_pkg::ADDR_W-1:0]  aw_addr,
  input wire logic [bbw_pkg::LEN_W-1:0]   aw_len,
  input wire logic                        aw_valid,
  input wire logic                        aw_ready,
  // write data channel
  input wire logic                        w_last,
  input wire logic                        w_valid,
  input wire logic                        w_ready,
  // write response channel
  input wire logic [bbw_pkg::ID_W-1:0]    b_id,
  input wire logic [bbw_pkg::RESP_W-1:0]  b_resp,
  input wire logic                        b_valid,
  input wire logic                        b_ready
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!aresetn);
  logic [2:0] open_r;
  // bursts whose address is in but whose last beat has not gone yet
  always_ff @(posedge clk_in) begin
    if (!aresetn) open_r <= 3'h0;
    else open_r <= open_r + 3'(aw_valid && aw_ready)
                   - 3'(w_valid && w_ready && w_last);
  end
  addr_stable_a: assert property (
    aw_valid && !aw_ready |=> aw_valid && $stable(aw_addr) && $stable(aw_id)
    && $stable(aw_len))
    else $error("address fields moved before acceptance");
  slot_full_a: assert property (
    aw_valid && aw_ready |=> !aw_ready)
    else $error("address ready stayed high with slot full");
  data_hold_a: assert property (
    w_valid && !w_ready |=> w_valid && $stable(w_last))
    else $error("data beat dropped before acceptance");
  resp_hold_a: assert property (
    b_valid && !b_ready |=> b_valid && $stable(b_id))
    else $error("response dropped before acceptance");
  resp_after_last_a: assert property (
    $rose(b_valid) |-> $past(w_valid && w_ready && w_last))
    else $error("response not right after last beat");
  data_after_addr_a: assert property (
    w_valid |-> open_r != 3'h0)
    else $error("data beat without accepted address");
  no_data_resp_a: assert property (
    b_valid |-> !w_ready)
    else $error("data taken while response pending");
  resp_okay_a: assert property (
    b_valid |-> b_resp == bbw_pkg::RESP_OKAY)
    else $error("last flag mismatch seen by slave");
  reset_quiet_a: assert property (
    disable iff (1'b0) !aresetn |=> !aw_valid && !w_valid && !b_valid)
    else $error("valid high after link reset");
endmodule
`default_nettype wire

// ===== tb/burst_bus_write_address_port_tb_top.sv
// testbench joining master and slave ends over the link
// assumes inputs change at the falling edge and outputs settle by then
`timescale 1ns/100ps
`default_nettype none
module burst_bus_write_address_port_tb_top;
  logic        clk_in = 1'b0;
  logic        sys_rst_in, aresetn, cmd_valid, cmd_ready, wd_valid, wd_ready;
  logic        rsp_valid, wr_en;
  logic [2:0]  cmd_id, cmd_size;
  logic [31:0] cmd_addr, wd_data, wr_addr, wr_data;
  logic [3:0]  cmd_len, rsp_id, wr_strb;
  logic [1:0]  cmd_burst, rsp_resp;
  logic [31:0] wa_q[$], wd_q[$];
  logic [5:0]  rs_q[$];
  int          error_cnt = 0;
  int          checks_done = 0;
  logic [8:0]  aw_attr;
  // 40 MHz clock
  always #12.5 clk_in = ~clk_in;
  bbw_if u_bbw_if (.aresetn(aresetn));
  bbw_master u_bbw_master (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .bus(u_bbw_if.mst), .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready),
    .cmd_id_in(cmd_id), .cmd_addr_in(cmd_addr), .cmd_len_in(cmd_len),
    .cmd_size_in(cmd_size), .cmd_burst_in(cmd_burst), .cmd_lock_in(2'h1),
    .cmd_cache_in(4'h3), .cmd_prot_in(3'h2), .wd_valid_in(wd_valid),
    .wd_ready_out(wd_ready), .wd_data_in(wd_data), .wd_strb_in(4'hf),
    .rsp_valid_out(rsp_valid), .rsp_id_out(rsp_id), .rsp_resp_out(rsp_resp));
  bbw_slave u_bbw_slave (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .bus(u_bbw_if.slv), .wr_en_out(wr_en), .wr_addr_out(wr_addr),
    .wr_data_out(wr_data), .wr_strb_out(wr_strb));
  bbw_chk u_bbw_chk (.clk_in(clk_in), .aresetn(aresetn),
    .aw_id(u_bbw_if.aw_id), .aw_addr(u_bbw_if.aw_addr),
    .aw_len(u_bbw_if.aw_len), .aw_valid(u_bbw_if.aw_valid),
    .aw_ready(u_bbw_if.aw_ready), .w_last(u_bbw_if.w_last),
    .w_valid(u_bbw_if.w_valid), .w_ready(u_bbw_if.w_ready),
    .b_id(u_bbw_if.b_id), .b_resp(u_bbw_if.b_resp),
    .b_valid(u_bbw_if.b_valid), .b_ready(u_bbw_if.b_ready));
  // lock, cache and protection fields as the master puts them on the link
  assign aw_attr = {u_bbw_if.aw_lock, u_bbw_if.aw_cache, u_bbw_if.aw_prot};
  // pulses last one cycle, so the falling edge sees each once
  always @(negedge clk_in) begin
    if (wr_en === 1'b1) begin
      wa_q.push_back(wr_addr);
      wd_q.push_back(wr_data);
    end
    if (rsp_valid === 1'b1) rs_q.push_back({rsp_id, rsp_resp});
  end
  task automatic conclude();
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // expected beat address from type, size and length
  function automatic logic [31:0] nxt(input logic [31:0] a,
    input logic [2:0] sz, input logic [1:0] bt, input logic [3:0] len);
    logic [31:0] n, w, b;
    n = (a & ~((32'h1 << sz) - 32'h1)) + (32'h1 << sz);
    w = (32'h1 << sz) * ({28'h0, len} + 32'h1);
    b = a & ~(w - 32'h1);
    if (bt == bbw_pkg::BURST_FIXED) return a;
    if (bt == bbw_pkg::BURST_WRAP && n == b + w) return b;
    return n;
  endfunction
  // offer a command and hold it until the edge that takes it
  task automatic cmd(input logic [2:0] id, input logic [31:0] a,
    input logic [3:0] len, input logic [1:0] bt);
    @(negedge clk_in);
    cmd_valid = 1'b1;
    cmd_id = id;
    cmd_addr = a;
    cmd_len = len;
    cmd_burst = bt;
    repeat (40) if (cmd_ready !== 1'b1) @(negedge clk_in);
    chk({31'h0, cmd_ready}, 32'h1);
    @(negedge clk_in);
    cmd_valid = 1'b0;
    // the taken address still stands on the link here
    chk(u_bbw_if.aw_addr, a);
    chk({28'h0, u_bbw_if.aw_id}, {28'h0, 1'b0, id});
    chk({23'h0, aw_attr}, {23'h0, 2'h1, 4'h3, 3'h2});
  endtask
  task automatic beat(input logic [31:0] d);
    @(negedge clk_in);
    wd_valid = 1'b1;
    wd_data = d;
    repeat (40) if (wd_ready !== 1'b1) @(negedge clk_in);
    chk({31'h0, wd_ready}, 32'h1);
    @(negedge clk_in);
    wd_valid = 1'b0;
  endtask
  task automatic expw(input logic [31:0] a, input logic [31:0] d);
    chk(wa_q.pop_front(), a);
    chk(wd_q.pop_front(), d);
  endtask
  task automatic expr(input logic [2:0] id);
    chk({26'h0, rs_q.pop_front()},
      {26'h0, 1'b0, id, bbw_pkg::RESP_OKAY});
  endtask
  // single burst: every address stepped, one answer after the last beat
  task automatic burst(input logic [2:0] id, input logic [31:0] a,
    input logic [3:0] len, input logic [1:0] bt, input logic [2:0] sz);
    logic [31:0] ea;
    cmd_size = sz;
    cmd(id, a, len, bt);
    for (int i = 0; i <= len; i++) beat(a ^ 32'(i));
    repeat (10) @(negedge clk_in);
    ea = a;
    for (int i = 0; i <= len; i++) begin
      expw(ea, a ^ 32'(i));
      ea = nxt(ea, sz, bt, len);
    end
    expr(id);
    chk(32'(wa_q.size() + rs_q.size()), 32'h0);
    chk({28'h0, wr_strb}, 32'hf);
  endtask
  // second address before the first burst's data; answered in order
  task automatic overlap();
    cmd_size = 3'h2;
    cmd(3'h5, 32'h0000_0100, 4'h1, bbw_pkg::BURST_INCR);
    cmd(3'h6, 32'h0000_0200, 4'h0, bbw_pkg::BURST_INCR);
    beat(32'ha1);
    beat(32'ha2);
    beat(32'hb1);
    repeat (10) @(negedge clk_in);
    expw(32'h0000_0100, 32'ha1);
    expw(32'h0000_0104, 32'ha2);
    expw(32'h0000_0200, 32'hb1);
    expr(3'h5);
    expr(3'h6);
  endtask
  // link reset low in mid-burst forgets the burst; a fresh one then runs
  task automatic midreset();
    cmd(3'h7, 32'h0000_0300, 4'h0, bbw_pkg::BURST_INCR);
    aresetn = 1'b0;
    repeat (2) @(negedge clk_in);
    chk({31'h0, u_bbw_if.aw_valid}, 32'h0);
    aresetn = 1'b1;
    // a beat offered after the reset finds no burst due and is refused
    @(negedge clk_in);
    wd_valid = 1'b1;
    wd_data = 32'hc1;
    repeat (4) @(negedge clk_in);
    chk({31'h0, wd_ready}, 32'h0);
    wd_valid = 1'b0;
    repeat (10) @(negedge clk_in);
    chk(32'(wa_q.size() + rs_q.size()), 32'h0);
    burst(3'h1, 32'h400, 4'h0, bbw_pkg::BURST_INCR, 3'h2);
  endtask
  // watchdog: the run needs well under a thousand cycles
  initial begin
    #(25 * 4000);
    error_cnt++;
    conclude();
  end
  initial begin
    sys_rst_in = 1'b1;
    aresetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_id = 3'h0;
    cmd_addr = 32'h0;
    cmd_len = 4'h0;
    cmd_size = 3'h0;
    cmd_burst = bbw_pkg::BURST_INCR;
    wd_valid = 1'b0;
    wd_data = 32'h0;
    repeat (10) @(negedge clk_in);
    sys_rst_in = 1'b0;
    aresetn = 1'b1;
    burst(3'h1, 32'h103, 4'h3, bbw_pkg::BURST_INCR, 3'h2);
    burst(3'h2, 32'h38, 4'h3, bbw_pkg::BURST_WRAP, 3'h2);
    burst(3'h3, 32'h200, 4'h1, bbw_pkg::BURST_FIXED, 3'h2);
    burst(3'h4, 32'h41, 4'hf, bbw_pkg::BURST_INCR, 3'h0);
    overlap();
    midreset();
    conclude();
  end
endmodule
`default_nettype wire
